// file: verilog/sfhp_port.sv
// Link front end of a serial flash: SPI, dual, quad and four-lane instruction mode.
// Assumes SCLK_I only toggles in frames and the flash core sits on CLK_SYS_I.
//
// Contract
// R1: Chip select high deselects the part and floats every lane.
// R2: Internal program, erase or status writes survive chip select rising.
// R3: After power-up, no instruction until chip select goes high to low.
// R4: Single lane: instruction, address, data sampled from lane 0 on rising clock.
// R5: Single lane: read data driven on lane 1, changing on falling clock.
// R6: Multi-lane: sample lanes on rising clock, drive them on falling clock.
// R7: Quad codes honoured only with quad enable; lanes 2,3 become data.
// R8: Low write-protect plus protect bits block status writes, unless quad enabled.
// R9: Modes 0 and 3 both work; master parks clock accordingly.
// R10: Codes 3Bh and BBh use lanes 0 and 1 both ways; the code takes the 3Bh address on lane 0 alone.
// R11: Codes 6Bh, EBh, E7h, E3h move data over all four lanes.
// R12: Code 38h enters four-lane instruction mode; instruction takes two clocks.
// R13: Modes are exclusive; code FFh returns to SPI mode.
// R14: Power-up and code 99h leave the part in SPI mode.
// R15: Four-lane mode entry needs quad enable set beforehand.
// R16: Hold only works in standard or dual operation with chip select low.
// R17: Hold starts at hold falling if clock low, else next falling clock; the code floats the lanes only at the next falling clock.
// R18: Hold ends at hold rising if clock low, else next falling clock; the code enables the lane drivers again only at the next falling clock.
// R19: While held: lanes float, clock and input ignored, state kept.
// R20: Master keeps chip select low through a hold.
// R21: Bytes go most significant bit or nibble first.
// R22: Chip select rising drops a partial instruction; decode restarts next frame.
`timescale 1ns/1ns
`default_nettype none

module sfhp_port (
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic [3:0] LANE_I,
  output logic [3:0] LANE_O,
  output logic [3:0] LANE_OE_O,
  input wire logic QUAD_ENABLE_I,
  input wire logic [1:0] PROT_BITS_I,
  input wire logic [7:0] TX_DATA_I,
  input wire logic TX_LOAD_I,
  output logic TX_BUSY_O,
  output logic RX_VALID_O,
  output logic [7:0] RX_DATA_O,
  output logic RX_FIRST_O,
  output logic QPI_MODE_O,
  output logic SELECTED_O,
  output logic WRITE_PROTECT_O
);

  // Reset reaches the link side asynchronously because SCLK_I stops between frames
  logic link_rst_q;

  // Link-side state
  logic [2:0] cnt_q;
  logic [7:0] sh_q;
  logic first_q;
  logic dead_q;
  sfhp_pkg::sfhp_width_t in_wid_q;
  sfhp_pkg::sfhp_width_t out_wid_q;
  logic qpi_q;
  sfhp_pkg::sfhp_rx_t rx_hold_q;
  logic rx_tgl_q;
  logic [7:0] osh_q;
  logic [3:0] ocnt_q;
  logic tx_ack_q;
  logic [2:0] lk_sync;
  logic qe_lk;
  logic armed_lk;
  logic tx_tgl_lk;

  // System-side state
  logic armed_q;
  logic [7:0] tx_q;
  logic tx_tgl_q;
  logic rx_seen_q;
  logic [4:0] sys_sync;
  logic cs_n_s;
  logic rx_tgl_s;
  logic qpi_s;
  logic wp_n_s;
  logic tx_ack_s;

  // Link-side combinational terms
  sfhp_pkg::sfhp_width_t cur_wid;
  logic [3:0] step;
  logic [3:0] sum;
  logic byte_done;
  logic [7:0] sh_next;
  logic hold_gate;
  logic held;
  logic tx_pending;
  logic [7:0] op;

  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] lanes,
    input sfhp_pkg::sfhp_width_t w);
    unique case (w)
      sfhp_pkg::SFHP_W1: shift_in = {sh[6:0], lanes[0]};
      sfhp_pkg::SFHP_W2: shift_in = {sh[5:0], lanes[1:0]};
      default: shift_in = {sh[3:0], lanes[3:0]};
    endcase
  endfunction

  function automatic logic [3:0] lane_bits(input logic [7:0] b, input sfhp_pkg::sfhp_width_t w);
    unique case (w)
      sfhp_pkg::SFHP_W1: lane_bits = {2'h0, b[7], 1'b0};
      sfhp_pkg::SFHP_W2: lane_bits = {2'h0, b[7:6]};
      default: lane_bits = b[7:4];
    endcase
  endfunction

  function automatic logic [3:0] lane_mask(input sfhp_pkg::sfhp_width_t w);
    unique case (w)
      sfhp_pkg::SFHP_W1: lane_mask = sfhp_pkg::OE_W1;
      sfhp_pkg::SFHP_W2: lane_mask = sfhp_pkg::OE_W2;
      default: lane_mask = sfhp_pkg::OE_W4;
    endcase
  endfunction

  function automatic logic [7:0] shift_out(input logic [7:0] b, input sfhp_pkg::sfhp_width_t w);
    unique case (w)
      sfhp_pkg::SFHP_W1: shift_out = {b[6:0], 1'b0};
      sfhp_pkg::SFHP_W2: shift_out = {b[5:0], 2'h0};
      default: shift_out = {b[3:0], 4'h0};
    endcase
  endfunction

  always_ff @(posedge CLK_SYS_I)
  begin
    link_rst_q <= RESET_I;
  end

  sfhp_sync #(
    .W(3)
  ) u_link_sync (
    .clk_i(SCLK_I),
    .clr_i(link_rst_q),
    .d_i({QUAD_ENABLE_I, armed_q, tx_tgl_q}),
    .q_o(lk_sync)
  );

  assign qe_lk = lk_sync[2];
  assign armed_lk = lk_sync[1];
  assign tx_tgl_lk = lk_sync[0];

  // The instruction byte arrives on one lane, or on four in four-lane mode
  always_comb
  begin
    if (first_q)
      cur_wid = qpi_q ? sfhp_pkg::SFHP_W4 : sfhp_pkg::SFHP_W1; // R12
    else
      cur_wid = in_wid_q;
    step = sfhp_pkg::sfhp_step(cur_wid);
    sum = {1'b0, cnt_q} + step;
    byte_done = sum[3];
    sh_next = shift_in(sh_q, LANE_I, cur_wid); // R4 R6 R21
    op = sh_next;
  end

  // Lane 3 is a hold input only while it is not a data lane
  assign hold_gate = !qe_lk && !qpi_q && (cur_wid != sfhp_pkg::SFHP_W4) && (out_wid_q != sfhp_pkg::SFHP_W4); // R16 R7
  // At a rising edge the pin level already reflects a hold taken or released while the clock was low
  assign held = hold_gate && !LANE_I[3]; // R17 R18 R19
  assign tx_pending = (tx_tgl_lk != tx_ack_q);

  // Frame state: cleared whenever chip select is high, so a partial instruction is lost
  always_ff @(posedge SCLK_I or posedge CS_N_I)
  begin
    if (CS_N_I)
    begin
      cnt_q <= 3'h0; // R22
      sh_q <= 8'h00;
      first_q <= 1'b1; // R9
      dead_q <= 1'b0;
      in_wid_q <= sfhp_pkg::SFHP_W1;
      out_wid_q <= sfhp_pkg::SFHP_W1;
    end
    else if (!held)
    begin
      cnt_q <= sum[2:0];
      sh_q <= sh_next;
      if (byte_done && first_q)
      begin
        first_q <= 1'b0;
        dead_q <= !armed_lk || (sfhp_pkg::sfhp_is_quad(op) && !qe_lk); // R3 R7
        in_wid_q <= sfhp_pkg::sfhp_addr_width(op, qpi_q); // R10 R11
        out_wid_q <= sfhp_pkg::sfhp_data_width(op, qpi_q); // R10 R11
      end
    end
  end

  // Persistent link state: survives chip select so the mode and the handshake stay intact
  always_ff @(posedge SCLK_I or posedge link_rst_q)
  begin
    if (link_rst_q)
    begin
      qpi_q <= 1'b0; // R14
      rx_tgl_q <= 1'b0;
      rx_hold_q <= '0;
    end
    else if (!CS_N_I && !held && byte_done)
    begin
      // A refused instruction byte is not forwarded either, since dead_q only settles on this edge
      if (!dead_q && (!first_q || (armed_lk && !(sfhp_pkg::sfhp_is_quad(op) && !qe_lk)))) // R7
      begin
        rx_hold_q <= '{first: first_q, data: sh_next};
        rx_tgl_q <= !rx_tgl_q;
      end
      if (first_q && armed_lk)
      begin
        if (op == sfhp_pkg::OP_QPI_ENTER && qe_lk)
          qpi_q <= 1'b1; // R12 R15
        else if (op == sfhp_pkg::OP_QPI_EXIT || op == sfhp_pkg::OP_SOFT_RESET)
          qpi_q <= 1'b0; // R13 R14
      end
    end
  end

  // Output shifter on the falling edge; a read byte starts only on a byte boundary
  always_ff @(negedge SCLK_I or posedge CS_N_I)
  begin
    if (CS_N_I)
    begin
      LANE_OE_O <= 4'h0; // R1
      LANE_O <= 4'h0;
      osh_q <= 8'h00;
      ocnt_q <= 4'h0;
    end
    else if (held)
    begin
      LANE_OE_O <= 4'h0; // R19
    end
    else if (ocnt_q != 4'h0)
    begin
      LANE_O <= lane_bits(osh_q, out_wid_q); // R5 R6
      LANE_OE_O <= lane_mask(out_wid_q);
      osh_q <= shift_out(osh_q, out_wid_q); // R21
      ocnt_q <= ocnt_q - sfhp_pkg::sfhp_step(out_wid_q);
    end
    else if (tx_pending && !first_q && !dead_q && cnt_q == 3'h0)
    begin
      LANE_O <= lane_bits(tx_q, out_wid_q); // R5 R6
      LANE_OE_O <= lane_mask(out_wid_q);
      osh_q <= shift_out(tx_q, out_wid_q);
      ocnt_q <= 4'(sfhp_pkg::BYTE_BITS) - sfhp_pkg::sfhp_step(out_wid_q);
    end
    else
    begin
      LANE_OE_O <= 4'h0;
    end
  end

  // Acknowledge toggle for the read byte, kept apart from the frame so it never resets with chip select
  always_ff @(negedge SCLK_I or posedge link_rst_q)
  begin
    if (link_rst_q)
      tx_ack_q <= 1'b0;
    else if (!CS_N_I && !held && ocnt_q == 4'h0 && tx_pending && !first_q && !dead_q && cnt_q == 3'h0)
      tx_ack_q <= !tx_ack_q;
  end

  sfhp_sync #(
    .W(5)
  ) u_sys_sync (
    .clk_i(CLK_SYS_I),
    .clr_i(1'b0),
    .d_i({CS_N_I, rx_tgl_q, qpi_q, LANE_I[2], tx_ack_q}),
    .q_o(sys_sync)
  );

  assign cs_n_s = sys_sync[4];
  assign rx_tgl_s = sys_sync[3];
  assign qpi_s = sys_sync[2];
  assign wp_n_s = sys_sync[1];
  assign tx_ack_s = sys_sync[0];

  // Arms once chip select has been seen high after reset; a frame already open then stays unarmed
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
      armed_q <= 1'b0; // R3
    else if (cs_n_s)
      armed_q <= 1'b1; // R3
  end

  // The received byte is held still for two link clocks after its toggle, far longer than the sync delay
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      rx_seen_q <= rx_tgl_s;
      RX_VALID_O <= 1'b0;
      RX_DATA_O <= 8'h00;
      RX_FIRST_O <= 1'b0;
    end
    else
    begin
      rx_seen_q <= rx_tgl_s;
      RX_VALID_O <= (rx_tgl_s != rx_seen_q);
      if (rx_tgl_s != rx_seen_q)
      begin
        RX_DATA_O <= rx_hold_q.data;
        RX_FIRST_O <= rx_hold_q.first;
      end
    end
  end

  // Read byte offer: tx_q is frozen until the link acknowledges, so the word crosses safely
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      tx_q <= 8'h00;
      tx_tgl_q <= 1'b0;
      TX_BUSY_O <= 1'b0;
    end
    else
    begin
      if (TX_LOAD_I && !TX_BUSY_O && tx_tgl_q == tx_ack_s)
      begin
        tx_q <= TX_DATA_I;
        tx_tgl_q <= !tx_tgl_q;
        TX_BUSY_O <= 1'b1;
      end
      else
      begin
        TX_BUSY_O <= (tx_tgl_q != tx_ack_s);
      end
    end
  end

  // Status toward the core; the core's own program and erase cycles are never touched here
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      QPI_MODE_O <= 1'b0;
      SELECTED_O <= 1'b0;
      WRITE_PROTECT_O <= 1'b0;
    end
    else
    begin
      QPI_MODE_O <= qpi_s;
      SELECTED_O <= !cs_n_s; // R2
      // Lane 2 is data once quad enable is set, so the pin cannot protect then
      WRITE_PROTECT_O <= !QUAD_ENABLE_I && (PROT_BITS_I == sfhp_pkg::PROT_HW) && !wp_n_s; // R8
    end
  end

endmodule

`default_nettype wire

// file: verilog/sfhp_pkg.sv
// Shared constants, types and decode helpers for the serial flash host port.
// Assumes a link master running SPI mode 0 or 3 and a flash core on the system clock.
`default_nettype none

package sfhp_pkg;

  localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO = 8'heb;
  localparam logic [7:0] OP_QUAD_WORD = 8'he7;
  localparam logic [7:0] OP_QUAD_OCTAL = 8'he3;
  localparam logic [7:0] OP_QPI_ENTER = 8'h38;
  localparam logic [7:0] OP_QPI_EXIT = 8'hff;
  localparam logic [7:0] OP_SOFT_RESET = 8'h99;

  localparam int BYTE_BITS = 8;
  localparam logic [1:0] PROT_HW = 2'h1;
  localparam logic [3:0] OE_W1 = 4'h2;
  localparam logic [3:0] OE_W2 = 4'h3;
  localparam logic [3:0] OE_W4 = 4'hf;

  typedef enum logic [1:0] {SFHP_W1, SFHP_W2, SFHP_W4} sfhp_width_t;

  typedef struct packed {
    logic first;
    logic [7:0] data;
  } sfhp_rx_t;

  function automatic logic [3:0] sfhp_step(input sfhp_width_t w);
    unique case (w)
      SFHP_W1: sfhp_step = 4'h1;
      SFHP_W2: sfhp_step = 4'h2;
      default: sfhp_step = 4'h4;
    endcase
  endfunction

  function automatic logic sfhp_is_quad(input logic [7:0] op);
    sfhp_is_quad = (op == OP_QUAD_OUT) || (op == OP_QUAD_IO) || (op == OP_QUAD_WORD) || (op == OP_QUAD_OCTAL);
  endfunction

  function automatic sfhp_width_t sfhp_addr_width(input logic [7:0] op, input logic four_lane_instruction_mode);
    if (four_lane_instruction_mode || op == OP_QUAD_IO || op == OP_QUAD_WORD || op == OP_QUAD_OCTAL)
      sfhp_addr_width = SFHP_W4;
    else if (op == OP_DUAL_IO)
      sfhp_addr_width = SFHP_W2;
    else
      sfhp_addr_width = SFHP_W1;
  endfunction

  function automatic sfhp_width_t sfhp_data_width(input logic [7:0] op, input logic four_lane_instruction_mode);
    if (four_lane_instruction_mode || sfhp_is_quad(op))
      sfhp_data_width = SFHP_W4;
    else if (op == OP_DUAL_OUT || op == OP_DUAL_IO)
      sfhp_data_width = SFHP_W2;
    else
      sfhp_data_width = SFHP_W1;
  endfunction

endpackage

`default_nettype wire

// file: verilog/sfhp_sync.sv
// Two-stage level synchroniser, one bit per lane of the vector.
// Assumes clr is a clean reset; it only ever loads zero.
`timescale 1ns/1ns
`default_nettype none

module sfhp_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage
  always_ff @(posedge clk_i or posedge clr_i)
  begin
    if (clr_i)
    begin
      meta_q <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule

`default_nettype wire

// file: test/sfhp_port_asserts.sv
// Pin-level checks for the serial flash host port.
// Assumes it is bound to sfhp_port and sees only its ports.
`timescale 1ns/1ns
`default_nettype none

module sfhp_port_chk (
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic [3:0] LANE_I,
  input wire logic [3:0] LANE_O,
  input wire logic [3:0] LANE_OE_O,
  input wire logic QUAD_ENABLE_I,
  input wire logic [1:0] PROT_BITS_I,
  input wire logic TX_LOAD_I,
  input wire logic TX_BUSY_O,
  input wire logic RX_VALID_O,
  input wire logic RX_FIRST_O,
  input wire logic QPI_MODE_O,
  input wire logic WRITE_PROTECT_O
);
  AST_CS_FLOAT: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    CS_N_I |-> LANE_OE_O == 4'h0) else $error("lanes driven while deselected");
  AST_LANE_HOLDS: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    SCLK_I && $past(SCLK_I) |-> $stable(LANE_O)) else $error("lane output moved with clock high");
  AST_NO_QUAD_LANES: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    !QUAD_ENABLE_I |-> LANE_OE_O[3:2] == 2'h0) else $error("upper lanes driven without quad enable");
  AST_QPI_NEEDS_QE: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    $rose(QPI_MODE_O) |-> QUAD_ENABLE_I) else $error("four-lane mode entered without quad enable");
  AST_WP_SET: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (!QUAD_ENABLE_I && PROT_BITS_I == sfhp_pkg::PROT_HW && !LANE_I[2]) [*5] |-> WRITE_PROTECT_O)
    else $error("status writes not blocked");
  AST_WP_QE: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    QUAD_ENABLE_I [*4] |-> !WRITE_PROTECT_O) else $error("write protect active with quad enable");
  AST_RX_PULSE: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    RX_VALID_O |=> !RX_VALID_O) else $error("receive pulse longer than one cycle");
  AST_TX_TAKE: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    TX_LOAD_I && !TX_BUSY_O |=> TX_BUSY_O) else $error("read byte not taken");
  AST_HOLD_FLOAT: assert property (@(posedge SCLK_I) disable iff (RESET_I)
    !LANE_I[3] && !$past(LANE_I[3]) && !CS_N_I && !QUAD_ENABLE_I |-> LANE_OE_O == 4'h0)
    else $error("lanes driven during hold");
  COV_FIRST: cover property (@(posedge CLK_SYS_I) RX_VALID_O && RX_FIRST_O);
  COV_QPI: cover property (@(posedge CLK_SYS_I) $rose(QPI_MODE_O));
  COV_QUAD: cover property (@(posedge CLK_SYS_I) LANE_OE_O == sfhp_pkg::OE_W4);
endmodule

bind sfhp_port sfhp_port_chk u_chk (.CLK_SYS_I, .RESET_I, .SCLK_I, .CS_N_I, .LANE_I, .LANE_O, .LANE_OE_O,
  .QUAD_ENABLE_I, .PROT_BITS_I, .TX_LOAD_I, .TX_BUSY_O, .RX_VALID_O, .RX_FIRST_O, .QPI_MODE_O,
  .WRITE_PROTECT_O);
`default_nettype wire

// file: test/sfhp_master.sv
// Behavioural link master: mode 0 or 3, one, two or four lanes.
// Assumes lanes 2 and 3 have board pull-ups; lanes 0 and 1 float.
`timescale 1ns/1ns
`default_nettype none

module sfhp_master (
  output logic sclk_o,
  output logic cs_n_o,
  output wire logic [3:0] lane_o,
  input wire logic [3:0] dev_d_i,
  input wire logic [3:0] dev_oe_i
);
  logic [3:0] md;
  logic [3:0] men;
  logic q;
  logic mode3;
  logic wp_n;
  logic hold_n;
  wire logic [3:0] mv = q ? md : {hold_n, wp_n, md[1:0]};
  wire logic [3:0] me = q ? men : {2'h3, men[1:0]};
  // A released lane 0 or 1 shows the inverse of the last bit driven on it, never the last bit
  assign lane_o = (dev_oe_i & dev_d_i) | (~dev_oe_i & me & mv) | (~dev_oe_i & ~me & {2'h3, ~md[1:0]});

  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    {md, men, q, mode3, wp_n, hold_n} = 12'h003;
  end

  task automatic pulse(input int n);
    repeat (n)
    begin
      #80 sclk_o = 1'b1;
      #80 sclk_o = 1'b0;
    end
  endtask

  task automatic frame_on();
    #37 cs_n_o = 1'b0;
    #80;
    if (mode3) sclk_o = 1'b0;
    #80;
  endtask

  task automatic frame_off();
    men = 4'h0;
    #40;
    if (mode3) sclk_o = 1'b1;
    #80 cs_n_o = 1'b1;
    #240;
  endtask

  task automatic send(input logic [7:0] b, input int w);
    q = (w == 4);
    men = 4'((1 << w) - 1);
    for (int i = 8 - w; i >= 0; i -= w)
    begin
      md = 4'((b >> i) & ((8'h1 << w) - 8'h1));
      pulse(1);
    end
  endtask

  task automatic recv(output logic [7:0] b, input int w, output logic [3:0] oe);
    q = (w == 4);
    men = 4'h0;
    b = 8'h00;
    for (int i = 0; i < 8; i += w)
    begin
      #80 sclk_o = 1'b1;
      oe = dev_oe_i;
      b = (w == 1) ? {b[6:0], lane_o[1]} : 8'((b << w) | (lane_o & 4'((1 << w) - 1)));
      #80 sclk_o = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// file: test/sfhp_port_tb_top.sv
// Self-checking bench for the serial flash host port.
// Assumes the link master model drives clock, select and lanes.
`timescale 1ns/1ns
`default_nettype none

module sfhp_port_tb_top;
  logic clk;
  logic rst;
  logic qe;
  logic [1:0] prot;
  logic [7:0] txd;
  logic txl;
  wire logic sclk;
  wire logic cs_n;
  wire logic [3:0] lane;
  logic [3:0] lo;
  logic [3:0] loe;
  logic busy;
  logic rxv;
  logic rxf;
  logic four_lane_instruction_mode;
  logic wp;
  logic [7:0] rxd;
  logic [8:0] rxq[$];
  logic [8:0] none[$];
  int mismatches;
  int n_checks;

  sfhp_port u_dut (.CLK_SYS_I(clk), .RESET_I(rst), .SCLK_I(sclk), .CS_N_I(cs_n), .LANE_I(lane), .LANE_O(lo),
    .LANE_OE_O(loe), .QUAD_ENABLE_I(qe), .PROT_BITS_I(prot), .TX_DATA_I(txd), .TX_LOAD_I(txl),
    .TX_BUSY_O(busy), .RX_VALID_O(rxv), .RX_DATA_O(rxd), .RX_FIRST_O(rxf), .QPI_MODE_O(four_lane_instruction_mode),
    .SELECTED_O(), .WRITE_PROTECT_O(wp));
  sfhp_master u_mst (.sclk_o(sclk), .cs_n_o(cs_n), .lane_o(lane), .dev_d_i(lo), .dev_oe_i(loe));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
    if (rxv === 1'b1) rxq.push_back({rxf, rxd});

  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rx_is(input string what, input logic [8:0] e[$]);
    repeat (30) @(posedge clk);
    chk(what, 9'(rxq.size()), 9'(e.size()));
    foreach (e[i]) chk(what, rxq[i], e[i]);
    rxq.delete();
  endtask

  task automatic frame1(input logic [7:0] op, input int w);
    u_mst.frame_on();
    u_mst.send(op, w);
    u_mst.frame_off();
    repeat (30) @(posedge clk);
    rxq.delete();
  endtask

  task automatic t_write(input logic m3);
    u_mst.mode3 = m3;
    u_mst.sclk_o = m3;
    u_mst.frame_on();
    u_mst.pulse(4);
    u_mst.frame_off();
    u_mst.frame_on();
    u_mst.send(8'h02, 1);
    u_mst.send(8'ha5, 1);
    u_mst.send(8'h3c, 1);
    u_mst.frame_off();
    rx_is("write", '{9'h102, 9'h0a5, 9'h03c});
    u_mst.mode3 = 1'b0;
    u_mst.sclk_o = 1'b0;
  endtask

  task automatic t_read();
    logic [7:0] ops[7] = '{8'h0b, 8'h3b, 8'hbb, 8'h6b, 8'heb, 8'he7, 8'he3};
    int ws[7] = '{1, 2, 2, 4, 4, 4, 4};
    logic [7:0] b;
    logic [3:0] oe;
    int fw[7] = '{1, 0, 1, 0, 1, 1, 1};
    logic [8:0] e[$];
    @(posedge clk) qe <= 1'b1;
    foreach (ops[i])
    begin
      @(posedge clk);
      txd <= 8'h81 + 8'(i * 17);
      txl <= 1'b1;
      @(posedge clk) txl <= 1'b0;
      u_mst.frame_on();
      u_mst.send(ops[i], 1);
      u_mst.recv(b, ws[i], oe);
      u_mst.frame_off();
      chk("read data", {1'b0, b}, {1'b0, 8'h81 + 8'(i * 17)});
      chk("read lanes", {5'h0, oe}, {5'h0, ws[i] == 1 ? sfhp_pkg::OE_W1 : ws[i] == 2 ? sfhp_pkg::OE_W2 :
        sfhp_pkg::OE_W4});
      // Lanes shifted in during the read complete an address byte for some codes
      e = '{{1'b1, ops[i]}};
      if (fw[i]) e.push_back((i == 0) ? 9'h000 : {1'b0, 8'h81 + 8'(i * 17)});
      rx_is("read op", e);
    end
    @(posedge clk)
    begin
      qe <= 1'b0;
      txd <= 8'h5a;
      txl <= 1'b1;
    end
    @(posedge clk) txl <= 1'b0;
    u_mst.frame_on();
    u_mst.send(8'h6b, 1);
    u_mst.recv(b, 4, oe);
    u_mst.frame_off();
    chk("refused lanes", {5'h0, oe}, 9'h0);
    rx_is("refused", none);
    chk("refused busy", {8'h0, busy}, 9'h1);
  endtask

  task automatic t_qpi();
    logic [7:0] ex[2] = '{8'hff, 8'h99};
    @(posedge clk) qe <= 1'b1;
    foreach (ex[i])
    begin
      frame1(8'h38, 1);
      chk("enter", {8'h0, four_lane_instruction_mode}, 9'h1);
      u_mst.frame_on();
      u_mst.send(8'h0b, 4);
      u_mst.frame_off();
      rx_is("nibble op", '{9'h10b});
      frame1(ex[i], 4);
      chk("leave", {8'h0, four_lane_instruction_mode}, 9'h0);
    end
    @(posedge clk) qe <= 1'b0;
    frame1(8'h38, 1);
    chk("enter no qe", {8'h0, four_lane_instruction_mode}, 9'h0);
  endtask

  task automatic t_hold();
    u_mst.frame_on();
    u_mst.send(8'h02, 1);
    // Select stays low through the pause
    u_mst.hold_n = 1'b0;
    u_mst.md = 4'h1;
    u_mst.pulse(3);
    u_mst.hold_n = 1'b1;
    u_mst.send(8'h44, 1);
    u_mst.frame_off();
    rx_is("hold", '{9'h102, 9'h044});
  endtask

  task automatic t_wp();
    u_mst.q = 1'b0;
    u_mst.wp_n = 1'b0;
    @(posedge clk) prot <= sfhp_pkg::PROT_HW;
    repeat (10) @(posedge clk);
    chk("wp on", {8'h0, wp}, 9'h1);
    qe <= 1'b1;
    repeat (10) @(posedge clk);
    chk("wp qe", {8'h0, wp}, 9'h0);
    qe <= 1'b0;
    u_mst.wp_n = 1'b1;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #400000;
    mismatches++;
    conclude();
  end

  initial
  begin
    {rst, qe, prot, txd, txl, mismatches, n_checks} = {1'b1, 12'h0, 64'h0};
    #1 u_mst.cs_n_o = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    u_mst.send(8'h02, 1);
    u_mst.frame_off();
    rx_is("unarmed", none);
    t_write(1'b0);
    t_write(1'b1);
    t_read();
    t_qpi();
    t_hold();
    t_wp();
    conclude();
  end
endmodule
`default_nettype wire
